// [src/pcs_pkg.sv]
// Shared constants for the PCI command and status register bank.
package pcs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration offsets (byte addresses).
  localparam logic [7:0]  PCS_CS_OFFSET        = 8'h04;
  localparam logic [7:0]  PCS_CAP_PTR_OFFSET   = 8'h34;

  ////////////////////////////////////////////////////////////////////////////////
  // Status flag positions.
  localparam int          PCS_NUM_FLAGS        = 6;
  localparam int          PCS_DETECTED_PAR_POS = 31;
  localparam int          PCS_SIG_SERR_POS     = 30;
  localparam int          PCS_RCV_MABORT_POS   = 29;
  localparam int          PCS_RCV_TABORT_POS   = 28;
  localparam int          PCS_SIG_TABORT_POS   = 27;
  localparam int          PCS_MST_DPAR_POS     = 24;

  // Field positions: fixed fields and the two enable bits.
  localparam int          PCS_DEVSEL_LSB       = 25;
  localparam int          PCS_TGT_B2B_POS      = 23;
  localparam int          PCS_HIGH_SPEED_POS   = 21;
  localparam int          PCS_CAP_LIST_POS     = 20;
  localparam int          PCS_MST_B2B_POS      = 9;
  localparam int          PCS_SYSTEM_ERROR_DRIVER_ENABLE_POS      = 8;
  localparam int          PCS_WAIT_POS         = 7;
  localparam int          PCS_PARITY_RESPONSE_ENABLE_POS       = 6;
  localparam int          PCS_PALETTE_POS      = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Constant and reset values.
  localparam logic [1:0]  PCS_DEVSEL_MEDIUM    = 2'h1;
  localparam logic        PCS_TGT_B2B_VAL      = 1'h1;
  localparam logic        PCS_HIGH_SPEED_VAL   = 1'h0;
  localparam logic        PCS_CAP_LIST_VAL     = 1'h1;
  localparam logic        PCS_MST_B2B_VAL      = 1'h0;
  localparam logic        PCS_WAIT_VAL         = 1'h0;
  localparam logic        PCS_PALETTE_VAL      = 1'h0;
  localparam logic        PCS_ENABLE_RST       = 1'h0;
  localparam logic        PCS_FLAG_RST         = 1'h0;
  localparam logic [7:0]  PCS_CAP_PTR_DEFAULT  = 8'h40;

endpackage : pcs_pkg

// [src/pcs_parity_gen.sv]
// Bus parity generator: even parity over address/data and command lines.
`timescale 1ns/10ps
`default_nettype none

module pcs_parity_gen (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Bus lines driven this cycle
  input  wire logic [31:0] ad_out,
  input  wire logic [3:0]  cbe_out,
  // Parity for the next cycle
  output logic             par_q
);

  logic par_d;

  // Parity lags the lines it covers by one clock, so it is registered here.
  always_comb begin
    par_d = ^{ad_out, cbe_out};
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      par_q <= 1'h0;
    end else begin
      par_q <= par_d;
    end
  end

endmodule // pcs_parity_gen

`default_nettype wire

// [src/pcs_command_status.sv]
// PCI command and status register bank with error flags and error pin drive.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] Set the detected-parity flag on a master data parity error or a target address or data parity error.
// [R2] Set the signalled-system-error flag when the target drives SERR# for an address parity error.
// [R3] Set the received-master-abort flag when a transaction this master started ends in Master-Abort.
// [R4] Set the received-target-abort flag when this master sees its transaction ended by Target-Abort.
// [R5] Set the signalled-target-abort flag whenever this target ends a transaction with Target-Abort.
// [R6] Device select timing reads as 01 and the target claims with medium decode timing.
// [R7] With parity response on, set the master data parity flag when this master or its target asserts PERR#.
// [R8] Target fast back-to-back capability reads as 1 and such transactions are accepted.
// [R9] The high-speed capability bit reads as 0, the device being a 33 MHz part.
// [R10] The capabilities-list bit reads as 1 and offset 34h holds the capability pointer.
// [R11] The master fast back-to-back bit reads as 0 and the master never issues such transfers.
// [R12] SERR# is driven only with the system-error enable set, and reports address parity errors with both enables set.
// [R13] The parity-response enable gates PERR# and the master data parity flag.
// [R14] PAR is always generated, regardless of the parity-response enable.
// [R15] The wait-cycle bit reads as 0 and no stepping is ever used.
// [R16] Flags clear on a write of 1, ignore a write of 0, and all flags and enables reset to 0.
module pcs_command_status
  import pcs_pkg::*;
#(
  parameter logic [7:0] CAP_POINTER = pcs_pkg::PCS_CAP_PTR_DEFAULT
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata_q,
  output logic             cfg_ack_q,
  // Error events from the master and target paths
  input  wire logic        mst_data_perr,
  input  wire logic        tgt_addr_perr,
  input  wire logic        tgt_data_perr,
  input  wire logic        mst_abort_rcvd,
  input  wire logic        tgt_abort_rcvd,
  input  wire logic        tgt_abort_sent,
  input  wire logic        tgt_perr_seen,
  // Parity generation
  input  wire logic [31:0] ad_out,
  input  wire logic [3:0]  cbe_out,
  input  wire logic        ad_drive,
  output logic             par_o,
  output logic             par_oe_q,
  // Error pins, open drain
  output logic             perr_n_o_q,
  output logic             perr_n_oe_q,
  output logic             serr_n_o_q,
  output logic             serr_n_oe_q,
  // Settings seen by the data paths
  output logic             parity_response_enable_q,
  output logic             system_error_driver_enable_q,
  output logic [1:0]       devsel_timing_q,
  output logic             target_back_to_back_capable_q,
  output logic             master_back_to_back_enable_q,
  output logic             stepping_enable_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Flag layout.

  localparam int FLAG_POS [PCS_NUM_FLAGS] = '{
    PCS_DETECTED_PAR_POS, PCS_SIG_SERR_POS, PCS_RCV_MABORT_POS,
    PCS_RCV_TABORT_POS, PCS_SIG_TABORT_POS, PCS_MST_DPAR_POS
  };

  logic [PCS_NUM_FLAGS-1:0] flag_set;
  logic [PCS_NUM_FLAGS-1:0] flag_q;
  logic [PCS_NUM_FLAGS-1:0] flag_d;
  logic                     cs_hit;
  logic                     serr_fire;
  logic                     perr_fire;

  assign cs_hit = (cfg_addr == PCS_CS_OFFSET);

  ////////////////////////////////////////////////////////////////////////////////
  // Error pin decisions.

  // SERR# needs both enables; the enable alone never lets it out.
  assign serr_fire = tgt_addr_perr && system_error_driver_enable_q
                     && parity_response_enable_q;                              // [R12]
  assign perr_fire = (mst_data_perr || tgt_data_perr) && parity_response_enable_q; // [R13]

  always_comb begin
    flag_set    = '0;
    flag_set[0] = mst_data_perr || tgt_addr_perr || tgt_data_perr;           // [R1]
    flag_set[1] = serr_fire;                                                 // [R2]
    flag_set[2] = mst_abort_rcvd;                                            // [R3]
    flag_set[3] = tgt_abort_rcvd;                                            // [R4]
    flag_set[4] = tgt_abort_sent;                                            // [R5]
    flag_set[5] = parity_response_enable_q && (mst_data_perr || tgt_perr_seen); // [R7] [R13]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flags; an event in the clearing cycle wins over the clear.

  for (genvar i = 0; i < PCS_NUM_FLAGS; i++) begin : g_flag
    logic clr;

    always_comb begin
      clr       = cfg_wr && cs_hit && cfg_be[FLAG_POS[i] / 8] && cfg_wdata[FLAG_POS[i]];
      flag_d[i] = flag_set[i] || (flag_q[i] && !clr);                        // [R16]
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        flag_q[i] <= PCS_FLAG_RST;                                           // [R16]
      end else begin
        flag_q[i] <= flag_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Enables and pin drive.

  logic        parity_response_enable_d;
  logic        system_error_driver_enable_d;
  logic        perr_oe_d;
  logic        serr_oe_d;
  logic        par_oe_d;

  always_comb begin
    parity_response_enable_d  = parity_response_enable_q;
    system_error_driver_enable_d = system_error_driver_enable_q;
    if (cfg_wr && cs_hit && cfg_be[PCS_PARITY_RESPONSE_ENABLE_POS / 8]) begin
      parity_response_enable_d = cfg_wdata[PCS_PARITY_RESPONSE_ENABLE_POS];
    end
    if (cfg_wr && cs_hit && cfg_be[PCS_SYSTEM_ERROR_DRIVER_ENABLE_POS / 8]) begin
      system_error_driver_enable_d = cfg_wdata[PCS_SYSTEM_ERROR_DRIVER_ENABLE_POS];
    end
    perr_oe_d = perr_fire;                                                   // [R13]
    serr_oe_d = serr_fire;                                                   // [R2] [R12]
    par_oe_d  = ad_drive;                                                    // [R14]
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      parity_response_enable_q     <= PCS_ENABLE_RST;                        // [R16]
      system_error_driver_enable_q <= PCS_ENABLE_RST;                        // [R16]
      perr_n_oe_q                  <= 1'h0;
      serr_n_oe_q                  <= 1'h0;
      par_oe_q                     <= 1'h0;
    end else begin
      parity_response_enable_q     <= parity_response_enable_d;
      system_error_driver_enable_q <= system_error_driver_enable_d;
      perr_n_oe_q                  <= perr_oe_d;
      serr_n_oe_q                  <= serr_oe_d;
      par_oe_q                     <= par_oe_d;
    end
  end

  // Open-drain pins only ever pull low, so their data is constant.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      perr_n_o_q <= 1'h0;
      serr_n_o_q <= 1'h0;
    end else begin
      perr_n_o_q <= 1'h0;
      serr_n_o_q <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fixed capability outputs, held in flops so every output is registered.

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      devsel_timing_q               <= PCS_DEVSEL_MEDIUM;                    // [R6]
      target_back_to_back_capable_q <= PCS_TGT_B2B_VAL;                      // [R8]
      master_back_to_back_enable_q  <= PCS_MST_B2B_VAL;                      // [R11]
      stepping_enable_q             <= PCS_WAIT_VAL;                         // [R15]
    end else begin
      devsel_timing_q               <= PCS_DEVSEL_MEDIUM;                    // [R6]
      target_back_to_back_capable_q <= PCS_TGT_B2B_VAL;                      // [R8]
      master_back_to_back_enable_q  <= PCS_MST_B2B_VAL;                      // [R11]
      stepping_enable_q             <= PCS_WAIT_VAL;                         // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parity generation runs whatever the enables say.

  pcs_parity_gen u_parity (
    .mclk    (mclk),
    .rstn    (rstn),
    .ad_out  (ad_out),
    .cbe_out (cbe_out),
    .par_q   (par_o)                                                         // [R14]
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle from request to data; unmapped offsets read zero.

  logic [31:0] rdata_d;
  logic        ack_d;
  logic [31:0] cs_word;

  always_comb begin
    cs_word                                     = '0;
    for (int k = 0; k < PCS_NUM_FLAGS; k++) begin
      cs_word[FLAG_POS[k]] = flag_q[k];
    end
    cs_word[PCS_DEVSEL_LSB +: 2]                = PCS_DEVSEL_MEDIUM;         // [R6]
    cs_word[PCS_TGT_B2B_POS]                    = PCS_TGT_B2B_VAL;           // [R8]
    cs_word[PCS_HIGH_SPEED_POS]                 = PCS_HIGH_SPEED_VAL;        // [R9]
    cs_word[PCS_CAP_LIST_POS]                   = PCS_CAP_LIST_VAL;          // [R10]
    cs_word[PCS_MST_B2B_POS]                    = PCS_MST_B2B_VAL;           // [R11]
    cs_word[PCS_SYSTEM_ERROR_DRIVER_ENABLE_POS]                    = system_error_driver_enable_q;
    cs_word[PCS_WAIT_POS]                       = PCS_WAIT_VAL;              // [R15]
    cs_word[PCS_PARITY_RESPONSE_ENABLE_POS]                     = parity_response_enable_q;
    cs_word[PCS_PALETTE_POS]                    = PCS_PALETTE_VAL;

    rdata_d = '0;
    ack_d   = cfg_rd || cfg_wr;
    if (cfg_rd) begin
      if (cs_hit) begin
        rdata_d = cs_word;
      end else if (cfg_addr == PCS_CAP_PTR_OFFSET) begin
        rdata_d = {24'h000000, CAP_POINTER};                                 // [R10]
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata_q <= 32'h00000000;
      cfg_ack_q   <= 1'h0;
    end else begin
      cfg_rdata_q <= rdata_d;
      cfg_ack_q   <= ack_d;
    end
  end

endmodule // pcs_command_status

`default_nettype wire

// [verification/pcs_command_status_props.sv]
// Checker for the command and status register bank, bound to the design top.
`timescale 1ns/10ps
`default_nettype none

module pcs_command_status_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // Configuration access
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  // Error events
  input wire logic        mst_data_perr,
  input wire logic        tgt_addr_perr,
  input wire logic        tgt_data_perr,
  input wire logic        mst_abort_rcvd,
  input wire logic        tgt_abort_rcvd,
  input wire logic        tgt_abort_sent,
  // Pins and settings
  input wire logic        perr_n_oe_q,
  input wire logic        serr_n_oe_q,
  input wire logic        parity_response_enable_q,
  input wire logic        system_error_driver_enable_q,
  input wire logic [1:0]  devsel_timing_q,
  input wire logic        target_back_to_back_capable_q,
  input wire logic        master_back_to_back_enable_q,
  input wire logic        stepping_enable_q
);
  import pcs_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_cs_read;
    cfg_rd && cfg_addr == PCS_CS_OFFSET;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_serr_drive: assert property (
    serr_n_oe_q == $past(tgt_addr_perr && system_error_driver_enable_q && parity_response_enable_q))
    else $error("serr drive wrong");
  a_perr_drive: assert property (
    perr_n_oe_q == $past((mst_data_perr || tgt_data_perr) && parity_response_enable_q))
    else $error("perr drive wrong");
  a_fixed_outputs: assert property (
    devsel_timing_q == 2'h1 && target_back_to_back_capable_q && !master_back_to_back_enable_q && !stepping_enable_q)
    else $error("fixed outputs wrong");
  a_fixed_read: assert property (
    s_cs_read |=> cfg_rdata_q[26:25] == 2'h1 && cfg_rdata_q[23] && !cfg_rdata_q[21] && cfg_rdata_q[20]
      && !cfg_rdata_q[9] && !cfg_rdata_q[7] && !cfg_rdata_q[5])
    else $error("fixed fields wrong");
  a_parity_flag: assert property (
    (mst_data_perr || tgt_addr_perr || tgt_data_perr) ##1 s_cs_read |=> cfg_rdata_q[31])
    else $error("parity flag not set");
  a_master_abort: assert property (
    mst_abort_rcvd ##1 s_cs_read |=> cfg_rdata_q[29]) else $error("master abort flag not set");
  a_target_abort: assert property (
    tgt_abort_rcvd ##1 s_cs_read |=> cfg_rdata_q[28]) else $error("target abort flag not set");
  a_sent_abort: assert property (
    tgt_abort_sent ##1 s_cs_read |=> cfg_rdata_q[27]) else $error("sent abort flag not set");
endmodule // pcs_command_status_props

bind pcs_command_status pcs_command_status_props pcs_command_status_props_inst (.*);

`default_nettype wire

// [verification/pcs_bus_agent.sv]
// Far-side bus model: pull-ups on the open-drain error lines.
`timescale 1ns/10ps
`default_nettype none

module pcs_bus_agent (
  // Open-drain drive from the bridge
  input  wire logic perr_n_o,
  input  wire logic perr_n_oe,
  input  wire logic serr_n_o,
  input  wire logic serr_n_oe,
  // Resolved bus lines
  output logic      perr_n,
  output logic      serr_n
);
  // A released line floats up through the system pull-up, never holding its last level.
  assign perr_n = perr_n_oe ? perr_n_o : 1'h1;
  assign serr_n = serr_n_oe ? serr_n_o : 1'h1;
endmodule // pcs_bus_agent

`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench for the command and status register bank.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import pcs_pkg::*;
  // Reset starts high so that its first fall is a real edge that the asynchronous flops see.
  logic mclk = 0, rstn = 1, cfg_wr = 0, cfg_rd = 0, ad_drive = 0;
  logic [7:0] cfg_addr = 8'h0;
  logic [3:0] cfg_be = 4'h0, cbe_out = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, ad_out = 32'h0, cfg_rdata_q, rd;
  logic [6:0] ev = 7'h0;
  logic mst_data_perr, tgt_addr_perr, tgt_data_perr, mst_abort_rcvd, tgt_abort_rcvd, tgt_abort_sent, tgt_perr_seen;
  logic cfg_ack_q, par_o, par_oe_q, perr_n_o_q, perr_n_oe_q, serr_n_o_q, serr_n_oe_q, perr_n, serr_n;
  logic parity_response_enable_q, system_error_driver_enable_q, target_back_to_back_capable_q;
  logic master_back_to_back_enable_q, stepping_enable_q;
  logic [1:0] devsel_timing_q;
  int fails = 0, tests_run = 0, cycles = 0;
  logic [31:0] flag0 [7] = '{32'h8000_0000, 32'h8000_0000, 32'h8000_0000, 32'h2000_0000, 32'h1000_0000,
                            32'h0800_0000, 32'h0};
  logic [31:0] flag1 [7] = '{32'h8100_0000, 32'hc000_0000, 32'h8000_0000, 32'h2000_0000, 32'h1000_0000,
                            32'h0800_0000, 32'h0100_0000};
  assign {mst_data_perr, tgt_addr_perr, tgt_data_perr, mst_abort_rcvd, tgt_abort_rcvd, tgt_abort_sent,
          tgt_perr_seen} = ev;
  pcs_command_status pcs_command_status_inst (
    .mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_ack_q(cfg_ack_q), .mst_data_perr(mst_data_perr),
    .tgt_addr_perr(tgt_addr_perr), .tgt_data_perr(tgt_data_perr), .mst_abort_rcvd(mst_abort_rcvd),
    .tgt_abort_rcvd(tgt_abort_rcvd), .tgt_abort_sent(tgt_abort_sent), .tgt_perr_seen(tgt_perr_seen),
    .ad_out(ad_out), .cbe_out(cbe_out), .ad_drive(ad_drive), .par_o(par_o), .par_oe_q(par_oe_q),
    .perr_n_o_q(perr_n_o_q), .perr_n_oe_q(perr_n_oe_q), .serr_n_o_q(serr_n_o_q), .serr_n_oe_q(serr_n_oe_q),
    .parity_response_enable_q(parity_response_enable_q),
    .system_error_driver_enable_q(system_error_driver_enable_q), .devsel_timing_q(devsel_timing_q),
    .target_back_to_back_capable_q(target_back_to_back_capable_q),
    .master_back_to_back_enable_q(master_back_to_back_enable_q), .stepping_enable_q(stepping_enable_q));
  pcs_bus_agent pcs_bus_agent_inst (.perr_n_o(perr_n_o_q), .perr_n_oe(perr_n_oe_q), .serr_n_o(serr_n_o_q),
                                    .serr_n_oe(serr_n_oe_q), .perr_n(perr_n), .serr_n(serr_n));
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic req(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr <= w; cfg_rd <= !w; cfg_addr <= a; cfg_be <= be; cfg_wdata <= d;
  endtask
  // Ack must follow one cycle after the request; read data is taken in that cycle.
  task automatic done();
    @(posedge mclk);
    cfg_wr <= 1'h0;
    cfg_rd <= 1'h0;
    #1 check("ack", cfg_ack_q, 32'h1);
    rd = cfg_rdata_q;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk);
    req(w, a, be, d);
    done();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_fixed();
    xfer(0, PCS_CS_OFFSET, 4'hf, 32'h0); check("cs reset", rd, 32'h0290_0000);
    xfer(0, PCS_CAP_PTR_OFFSET, 4'hf, 32'h0); check("cap ptr", rd, {24'h0, PCS_CAP_PTR_DEFAULT});
    xfer(0, 8'h08, 4'hf, 32'h0); check("unmapped", rd, 32'h0);
    xfer(1, PCS_CS_OFFSET, 4'hf, 32'hffff_ffff);
    xfer(0, PCS_CS_OFFSET, 4'hf, 32'h0); check("cs ro", rd, 32'h0290_0140);
    check("enables", {30'h0, parity_response_enable_q, system_error_driver_enable_q}, 32'h3);
  endtask
  // Each event alone, then a write of 0 that must keep the flag and a write of 1 that clears it.
  task automatic t_events(input logic en);
    logic [31:0] base;
    base = 32'h0290_0000 | (en ? 32'h0000_0140 : 32'h0);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      ev <= 7'h40 >> i;
      @(posedge mclk);
      ev <= 7'h0;
      req(0, PCS_CS_OFFSET, 4'hf, 32'h0);
      #1 check("serr_n", serr_n, {31'h0, !(en && i == 1)});
      check("perr_n", perr_n, {31'h0, !(en && (i == 0 || i == 2))});
      done();
      check("cs flags", rd, base | (en ? flag1[i] : flag0[i]));
      xfer(1, PCS_CS_OFFSET, 4'h8, 32'h0);
      xfer(0, PCS_CS_OFFSET, 4'hf, 32'h0); check("cs keep", rd, base | (en ? flag1[i] : flag0[i]));
      xfer(1, PCS_CS_OFFSET, 4'h8, 32'hff00_0000);
      xfer(0, PCS_CS_OFFSET, 4'hf, 32'h0); check("cs clear", rd, base);
    end
  endtask
  task automatic t_parity(input logic [31:0] a, input logic [3:0] c, input logic drv);
    @(posedge mclk);
    ad_out <= a; cbe_out <= c; ad_drive <= drv;
    @(posedge mclk);
    #1 check("par", par_o, {31'h0, ^{a, c}});
    check("par_oe", par_oe_q, {31'h0, drv});
  endtask
  // An event in the same cycle as a write-1 clear of its flag must leave the flag set.
  task automatic t_set_wins();
    @(posedge mclk);
    ev <= 7'h08;
    req(1, PCS_CS_OFFSET, 4'h8, 32'h2000_0000);
    @(posedge mclk);
    ev <= 7'h0;
    cfg_wr <= 1'h0;
    xfer(0, PCS_CS_OFFSET, 4'hf, 32'h0);
    check("set wins", rd, 32'h2290_0000);
    xfer(1, PCS_CS_OFFSET, 4'h8, 32'h2000_0000);
    xfer(0, PCS_CS_OFFSET, 4'hf, 32'h0);
    check("set wins clear", rd, 32'h0290_0000);
  endtask
  // A bus reset in mid-run must drop enables, flags and pin drive that were live.
  task automatic t_reset_mid();
    xfer(1, PCS_CS_OFFSET, 4'hf, 32'h0000_0140);
    @(posedge mclk);
    ev <= 7'h10;
    @(posedge mclk);
    ev <= 7'h0;
    rstn <= 1'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'h1;
    #1;
    check("enables reset", {30'h0, parity_response_enable_q, system_error_driver_enable_q}, 32'h0);
    check("perr oe reset", perr_n_oe_q, 32'h0);
    xfer(0, PCS_CS_OFFSET, 4'hf, 32'h0);
    check("cs mid reset", rd, 32'h0290_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    rstn <= 1'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'h1;
    t_reset_and_fixed();
    t_events(1'h1);
    t_parity(32'h1234_5678, 4'ha, 1'h1);
    xfer(1, PCS_CS_OFFSET, 4'h3, 32'h0);
    t_events(1'h0);
    t_parity(32'h0000_0001, 4'h0, 1'h0);
    t_parity(32'h8000_0001, 4'h7, 1'h1);
    t_set_wins();
    t_reset_mid();
    finish_test();
  end
endmodule // tb

`default_nettype wire
